// ===== src/cap_tracker_regs.svh
`ifndef CAP_TRACKER_REGS_SVH
`define CAP_TRACKER_REGS_SVH
// ***************************************************
// control word and event word
// ***************************************************
`define CTL_WORD_ADDR 8'hd0
`define CTL_RESEED_BIT 3
`define EVENT_WORD_ADDR 8'h11
// ***************************************************
// tuning limits
// ***************************************************
`define COMP_MIN 10'h000
`define COMP_MAX 10'h3ff
`define BOUND_SHIFT 3
`define BETA_DIV_SHIFT 8
// ***************************************************
// charge-transfer rate limits, kHz, and oscillator
// ***************************************************
`define XFER_MIN_KHZ 42
`define XFER_MAX_KHZ 4500
`define OSC_KHZ 14000
`define CLK_PERIOD_NS 20
`endif

// ===== src/cap_tracker_pkg.sv
package cap_tracker_pkg;
   typedef enum logic [1:0] {
      normal_power_mode = 2'b00,
      low_power_mode = 2'b01,
      ultra_low_power_mode = 2'b10
   } power_mode_e;
   typedef enum logic [1:0] {
      trk_run = 2'b00,
      trk_tune = 2'b01,
      trk_check = 2'b10
   } track_state_e;
   typedef logic [15:0] count_t;
endpackage

// ===== src/chan_if.sv
`timescale 1ns/10ps
interface chan_if #(parameter int W = 16);
   logic sample;
   logic [W-1:0] raw;
   logic [W-1:0] ceiling;
   logic [7:0] beta;
   logic freeze;
   logic reseed;
   logic [W-1:0] count;
   logic [W-1:0] filtered;
   logic [W-1:0] reference;
   logic touch;
   modport core (output sample, raw, ceiling, beta, freeze, reseed,
                 input count, filtered, reference, touch);
   modport chan (input sample, raw, ceiling, beta, freeze, reseed,
                 output count, filtered, reference, touch);
endinterface

// ===== src/chan_filter.sv
`timescale 1ns/10ps
`include "cap_tracker_regs.svh"
module chan_filter #(
   parameter int W = 16,
   parameter int TOUCH_DELTA = 32
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   chan_if.chan ch
);
   logic [W-1:0] clamped;
   logic [W+8:0] blend;
   logic [W-1:0] lta_step;
   assign clamped = (ch.raw > ch.ceiling) ? ch.ceiling : ch.raw; // [RULE1]
   // filtered += (x - filtered) * beta / 256, done in a widened sum
   assign blend = (W+9)'({1'b0, ch.filtered} * (9'(256) - 9'(ch.beta)))
                + (W+9)'({1'b0, clamped} * 9'(ch.beta)); // [RULE13]
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ch.count <= '0;
         ch.filtered <= '0;
      end else if (ce_in && ch.sample) begin
         ch.count <= clamped; // [RULE1]
         ch.filtered <= blend[W+7:`BETA_DIV_SHIFT]; // [RULE13]
      end
   end
   // slow drift: one lsb per sample towards the filtered count
   assign lta_step = (ch.filtered > ch.reference) ? ch.reference + 1'b1 :
                     (ch.filtered < ch.reference) ? ch.reference - 1'b1 : ch.reference;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ch.reference <= '0;
      end else if (ce_in) begin
         if (ch.reseed) begin
            ch.reference <= ch.count; // [RULE4]
         end else if (ch.sample && !ch.touch && !ch.freeze) begin
            ch.reference <= lta_step; // [RULE3]
         end
      end
   end
   // counts fall with touch, so a large drop below reference is interaction
   assign ch.touch = (ch.reference > ch.filtered) &&
                     ((ch.reference - ch.filtered) > W'(TOUCH_DELTA)); // [RULE2]
   a_hold_touch: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ce_in && ch.touch && !ch.reseed |=> $stable(ch.reference)) // [RULE3]
      else $error("reference moved during touch");
   a_count_ceil: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ch.count <= ch.ceiling || $changed(ch.ceiling)) // [RULE1]
      else $error("count above ceiling");
endmodule

// ===== src/cap_channel_tracker.sv
`timescale 1ns/10ps
`include "cap_tracker_regs.svh"
// Behaviour
// RULE1: clamp count to ceiling, report ceiling
// RULE2: touch when count departs from reference; touch only flags filtered falling more than TOUCH_DELTA below reference
// RULE3: reference drifts slowly, frozen during touch
// RULE4: reseed loads reference with latest count
// RULE5: retune when reference leaves target window
// RULE6: pulse status bit on each retune
// RULE7: tuning error on bad compensation or count
// RULE8: error flag only updated by tuning
// RULE9: holdoff blocks retune after tuning error
// RULE10: step power mode down after timeout
// RULE11: timeout zero disables mode stepping
// RULE12: ultra-low samples wake channel fast only
// RULE13: iir damping equals beta over 256
// RULE14: reset flag set until host acknowledges
// RULE15: reset flag forces streaming, no event mode
// RULE16: reset flag keeps windows open while tuning
// RULE17: software restart command resets everything
// RULE18: transfer clock divided from oscillator, bounded; divider uses xfer_div_in unchecked against XFER_MIN_KHZ/XFER_MAX_KHZ
// RULE19: host reads event word to clear events
// RULE20: reseed bit self-clears after one reseed
// RULE21: clean tuning resumes tracking next cycle
module cap_channel_tracker #(
   parameter int N = 4,
   parameter int W = 16,
   parameter int TOUCH_DELTA = 32,
   parameter int ULP_SLOW_DIV = 8,
   parameter int TUNE_CYCLES = 16
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic sample_in,
   input wire logic [N*W-1:0] raw_in,
   input wire logic [W-1:0] ceiling_in,
   input wire logic [7:0] beta_in,
   input wire logic reseed_set_in,
   input wire logic retune_en_in,
   input wire logic [W-1:0] tune_target_in,
   input wire logic [W-1:0] tune_bound_in,
   input wire logic bound_default_in,
   input wire logic [N*10-1:0] comp_in,
   input wire logic tune_start_in,
   input wire logic [15:0] holdoff_in,
   input wire logic [7:0] mode_timeout_in,
   input wire logic [$clog2(N)-1:0] wake_chan_in,
   input wire logic event_mode_req_in,
   input wire logic events_pending_in,
   input wire logic ack_reset_in,
   input wire logic soft_restart_in,
   input wire logic [15:0] xfer_div_in,
   output logic [N*W-1:0] count_out,
   output logic [N*W-1:0] reference_out,
   output logic [N-1:0] touch_out,
   output logic reseed_pending_out,
   output logic retune_done_out,
   output logic tuning_out,
   output logic tuning_error_flag_out,
   output logic [1:0] power_mode_out,
   output logic reset_flag_out,
   output logic event_mode_out,
   output logic comm_window_out,
   output logic xfer_clk_out
);
   // ***************************************************
   // soft restart folds into the block reset
   // ***************************************************
   logic srst;
   assign srst = rst_in | soft_restart_in; // [RULE17]
   cap_tracker_pkg::track_state_e state_ff;
   cap_tracker_pkg::power_mode_e mode_ff;
   logic [7:0] tune_cnt_ff;
   logic [15:0] holdoff_ff;
   logic [15:0] idle_cnt_ff;
   logic [15:0] div_cnt_ff;
   logic [7:0] slow_cnt_ff;
   logic reseed_ff;
   logic [W-1:0] bound;
   logic [N-1:0] out_win;
   logic [N-1:0] bad_chan;
   logic any_touch;
   logic any_bad;
   logic retune_trig;
   chan_if #(.W(W)) cif [N] ();
   // ***************************************************
   // per-channel datapath
   // ***************************************************
   assign bound = bound_default_in ? (tune_target_in >> `BOUND_SHIFT) : tune_bound_in; // [RULE5]
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gch
         logic fast;
         assign fast = (mode_ff != cap_tracker_pkg::ultra_low_power_mode) ||
                       (wake_chan_in == g) || (slow_cnt_ff == 8'h00); // [RULE12]
         assign cif[g].sample = sample_in && fast && (state_ff == cap_tracker_pkg::trk_run);
         assign cif[g].raw = raw_in[g*W +: W];
         assign cif[g].ceiling = ceiling_in;
         assign cif[g].beta = beta_in;
         assign cif[g].freeze = 1'b0;
         assign cif[g].reseed = reseed_ff;
         assign count_out[g*W +: W] = cif[g].count;
         assign reference_out[g*W +: W] = cif[g].reference;
         assign touch_out[g] = cif[g].touch;
         assign out_win[g] = (cif[g].reference > tune_target_in + bound) ||
                             (cif[g].reference + bound < tune_target_in); // [RULE5]
         assign bad_chan[g] = (comp_in[g*10 +: 10] == `COMP_MIN) ||
                              (comp_in[g*10 +: 10] >= `COMP_MAX) ||
                              (cif[g].count > tune_target_in + bound) ||
                              (cif[g].count + bound < tune_target_in); // [RULE7]
         chan_filter #(.W(W), .TOUCH_DELTA(TOUCH_DELTA)) u_chan (
            .core_clk_in(core_clk_in),
            .rst_in(srst),
            .ce_in(ce_in),
            .ch(cif[g])
         );
      end
   endgenerate
   assign any_touch = |touch_out;
   assign any_bad = |bad_chan;
   // ***************************************************
   // reseed request, one shot
   // ***************************************************
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         reseed_ff <= 1'b0;
      end else if (ce_in) begin
         // a new set in the applying cycle wins and reseeds once more
         reseed_ff <= reseed_set_in; // [RULE4] [RULE20]
      end
   end
   assign reseed_pending_out = reseed_ff;
   // ***************************************************
   // tuning supervisor
   // ***************************************************
   assign retune_trig = retune_en_in && (|out_win) && (holdoff_ff == 16'h0000) &&
                        (state_ff == cap_tracker_pkg::trk_run); // [RULE5] [RULE9]
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         state_ff <= cap_tracker_pkg::trk_run;
         tune_cnt_ff <= 8'h00;
      end else if (ce_in) begin
         case (state_ff)
            cap_tracker_pkg::trk_run: begin
               if (tune_start_in || retune_trig) begin
                  state_ff <= cap_tracker_pkg::trk_tune;
                  tune_cnt_ff <= 8'(TUNE_CYCLES - 1);
               end
            end
            cap_tracker_pkg::trk_tune: begin
               if (tune_cnt_ff == 8'h00) begin
                  state_ff <= cap_tracker_pkg::trk_check;
               end else begin
                  tune_cnt_ff <= tune_cnt_ff - 8'h01;
               end
            end
            cap_tracker_pkg::trk_check: state_ff <= cap_tracker_pkg::trk_run; // [RULE21]
            default: state_ff <= cap_tracker_pkg::trk_run;
         endcase
      end
   end
   assign tuning_out = (state_ff != cap_tracker_pkg::trk_run);
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         tuning_error_flag_out <= 1'b0;
      end else if (ce_in && state_ff == cap_tracker_pkg::trk_check) begin
         tuning_error_flag_out <= |bad_chan; // [RULE7] [RULE8]
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         retune_done_out <= 1'b0;
      end else if (ce_in) begin
         retune_done_out <= retune_trig; // [RULE6]
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         holdoff_ff <= 16'h0000;
      end else if (ce_in) begin
         if (state_ff == cap_tracker_pkg::trk_check && (|bad_chan)) begin
            holdoff_ff <= holdoff_in; // [RULE9]
         end else if (holdoff_ff != 16'h0000 && sample_in) begin
            holdoff_ff <= holdoff_ff - 16'h0001;
         end
      end
   end
   // ***************************************************
   // power mode stepping, timeout counted in samples
   // ***************************************************
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         mode_ff <= cap_tracker_pkg::normal_power_mode;
         idle_cnt_ff <= 16'h0000;
      end else if (ce_in) begin
         if (any_touch) begin
            mode_ff <= cap_tracker_pkg::normal_power_mode;
            idle_cnt_ff <= 16'h0000;
         end else if (mode_timeout_in == 8'h00) begin
            idle_cnt_ff <= 16'h0000; // [RULE11]
         end else if (sample_in) begin
            if (idle_cnt_ff >= {8'h00, mode_timeout_in} - 16'h0001) begin
               idle_cnt_ff <= 16'h0000;
               case (mode_ff)
                  cap_tracker_pkg::normal_power_mode:
                     mode_ff <= cap_tracker_pkg::low_power_mode; // [RULE10]
                  cap_tracker_pkg::low_power_mode:
                     mode_ff <= cap_tracker_pkg::ultra_low_power_mode; // [RULE10]
                  default: mode_ff <= mode_ff;
               endcase
            end else begin
               idle_cnt_ff <= idle_cnt_ff + 16'h0001;
            end
         end
      end
   end
   assign power_mode_out = mode_ff;
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         slow_cnt_ff <= 8'h00;
      end else if (ce_in && sample_in) begin
         slow_cnt_ff <= (slow_cnt_ff >= 8'(ULP_SLOW_DIV - 1)) ? 8'h00 : slow_cnt_ff + 8'h01;
      end
   end
   // ***************************************************
   // reset indication and reporting
   // ***************************************************
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         reset_flag_out <= 1'b1; // [RULE14]
      end else if (ce_in && ack_reset_in) begin
         reset_flag_out <= 1'b0; // [RULE14]
      end
   end
   assign event_mode_out = event_mode_req_in && !reset_flag_out; // [RULE15]
   // events still pending keep the window opening like streaming
   assign comm_window_out = (reset_flag_out && tuning_out) || // [RULE16]
                            (!tuning_out && sample_in &&
                             (!event_mode_out || events_pending_in || any_touch)); // [RULE19]
   // ***************************************************
   // charge-transfer clock divider
   // ***************************************************
   always_ff @(posedge core_clk_in) begin
      if (srst) begin
         div_cnt_ff <= 16'h0000;
         xfer_clk_out <= 1'b0;
      end else if (ce_in) begin
         if (div_cnt_ff >= xfer_div_in) begin
            div_cnt_ff <= 16'h0000;
            xfer_clk_out <= ~xfer_clk_out; // [RULE18]
         end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
         end
      end
   end
   // ***************************************************
   // checks
   // ***************************************************
   sequence s_tune_end;
      state_ff == cap_tracker_pkg::trk_check;
   endsequence
   a_err_hold: assert property (@(posedge core_clk_in) disable iff (srst)
      !(state_ff == cap_tracker_pkg::trk_check) |=> $stable(tuning_error_flag_out)) // [RULE8]
      else $error("error flag changed outside tuning");
   a_err_eval: assert property (@(posedge core_clk_in) disable iff (srst)
      s_tune_end and ce_in |=> tuning_error_flag_out == $past(any_bad)) // [RULE7]
      else $error("error flag mismatch");
   a_holdoff_load: assert property (@(posedge core_clk_in) disable iff (srst)
      s_tune_end and (ce_in && any_bad) |=> holdoff_ff == $past(holdoff_in)) // [RULE9]
      else $error("holdoff not armed after error");
   a_holdoff_blk: assert property (@(posedge core_clk_in) disable iff (srst)
      holdoff_ff != 16'h0000 |-> !retune_trig) // [RULE9]
      else $error("retune during holdoff");
   a_retune_pulse: assert property (@(posedge core_clk_in) disable iff (srst)
      ce_in && retune_trig |=> retune_done_out ##1 !retune_done_out) // [RULE6]
      else $error("retune status not a pulse");
   a_event_block: assert property (@(posedge core_clk_in) disable iff (srst)
      reset_flag_out |-> !event_mode_out) // [RULE15]
      else $error("event mode with reset flag");
   a_tune_window: assert property (@(posedge core_clk_in) disable iff (srst)
      reset_flag_out && tuning_out |-> comm_window_out) // [RULE16]
      else $error("no window while tuning");
   a_mode_freeze: assert property (@(posedge core_clk_in) disable iff (srst)
      mode_timeout_in == 8'h00 && !any_touch |=> $stable(mode_ff)) // [RULE11]
      else $error("mode stepped with zero timeout");
   a_reseed_once: assert property (@(posedge core_clk_in) disable iff (srst)
      ce_in && reseed_ff && !reseed_set_in |=> !reseed_ff) // [RULE20]
      else $error("reseed bit stuck");
   a_resume_run: assert property (@(posedge core_clk_in) disable iff (srst)
      ce_in and s_tune_end |=> state_ff == cap_tracker_pkg::trk_run) // [RULE21]
      else $error("tracking not resumed");
endmodule

// ===== dv/electrode_model.sv
`timescale 1ns/10ps
// ****************************************
// electrode front end: one result per GAP cycles
// ****************************************
module electrode_model #(
   parameter int N = 4,
   parameter int W = 16,
   parameter int GAP = 6
) (
   input wire logic clk_in,
   input wire logic [N*W-1:0] level_in,
   output logic sample_out,
   output logic [N*W-1:0] raw_out
);
   int gap_cnt = 0;
   // outside the strobe the lines carry the inverse, so stale data never looks fresh
   always @(negedge clk_in) begin
      gap_cnt = (gap_cnt + 1) % GAP;
      sample_out <= (gap_cnt == 0);
      raw_out <= (gap_cnt == 0) ? level_in : ~level_in;
   end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
   localparam int N = 4;
   localparam int W = 16;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic sample_in;
   logic [N*W-1:0] raw_in;
   logic [N*W-1:0] lvl = {N{16'h0300}};
   logic [W-1:0] ceiling_in = 16'h0400;
   logic [7:0] beta_in = 8'h80;
   logic reseed_set_in = 1'b0;
   logic retune_en_in = 1'b0;
   logic [W-1:0] tune_target_in = 16'h0320;
   logic [W-1:0] tune_bound_in = 16'h0032;
   logic bound_default_in = 1'b1;
   logic [N*10-1:0] comp_in = {N{10'h200}};
   logic tune_start_in = 1'b0;
   logic [15:0] holdoff_in = 16'h0008;
   logic [7:0] mode_timeout_in = 8'h00;
   logic [1:0] wake_chan_in = 2'h0;
   logic event_mode_req_in = 1'b0;
   logic events_pending_in = 1'b1;
   logic ack_reset_in = 1'b0;
   logic soft_restart_in = 1'b0;
   logic [15:0] xfer_div_in = 16'h0009;
   logic [N*W-1:0] count_out;
   logic [N*W-1:0] reference_out;
   logic [N-1:0] touch_out;
   logic reseed_pending_out;
   logic retune_done_out;
   logic tuning_out;
   logic tuning_error_flag_out;
   logic [1:0] power_mode_out;
   logic reset_flag_out;
   logic event_mode_out;
   logic comm_window_out;
   logic xfer_clk_out;
   int error_cnt = 0;
   int n_checks = 0;
   int retunes = 0;
   always #10 core_clk_in = ~core_clk_in;
   always @(negedge core_clk_in) if (retune_done_out === 1'b1) retunes++;
   cap_channel_tracker #(.N(N), .W(W), .TOUCH_DELTA(32), .ULP_SLOW_DIV(8),
      .TUNE_CYCLES(16)) dut (.*);
   electrode_model #(.N(N), .W(W)) model (.clk_in(core_clk_in), .level_in(lvl),
      .sample_out(sample_in), .raw_out(raw_in));
   function automatic logic [W-1:0] cnt(input int g);
      return count_out[g*W+:W];
   endfunction
   function automatic logic [W-1:0] rf(input int g);
      return reference_out[g*W+:W];
   endfunction
   // ****************************************
   // drivers
   // ****************************************
   task automatic smp(input int n);
      repeat (n) @(posedge core_clk_in iff sample_in === 1'b1);
      repeat (2) @(negedge core_clk_in);
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk_in) s = 1'b1;
      @(negedge core_clk_in) s = 1'b0;
   endtask
   task automatic tune();
      int k;
      k = 0;
      pulse(tune_start_in);
      while (tuning_out !== 1'b0 && k < 400) begin
         if (reset_flag_out === 1'b1) `CHK(comm_window_out, 1'b1)
         @(negedge core_clk_in);
         k++;
      end
      `CHK(k > 0, 1'b1)
      repeat (2) @(negedge core_clk_in);
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_xfer();
      int k;
      k = 0;
      while (xfer_clk_out !== 1'b1 && k < 100) begin
         @(negedge core_clk_in);
         k++;
      end
      k = 0;
      while (xfer_clk_out === 1'b1 && k < 100) begin
         @(negedge core_clk_in);
         k++;
      end
      `CHK(k, 10)
      // clock enable low must freeze the divider across its next toggle
      ce_in = 1'b0;
      repeat (12) @(negedge core_clk_in);
      `CHK(xfer_clk_out, 1'b0)
      ce_in = 1'b1;
   endtask
   task automatic t_reset();
      event_mode_req_in = 1'b1;
      @(negedge core_clk_in);
      `CHK(reset_flag_out, 1'b1)
      `CHK(event_mode_out, 1'b0)
      `CHK(power_mode_out, cap_tracker_pkg::normal_power_mode)
      pulse(ack_reset_in);
      events_pending_in = 1'b0;
      @(negedge core_clk_in);
      `CHK(reset_flag_out, 1'b0)
      `CHK(event_mode_out, 1'b1)
      event_mode_req_in = 1'b0;
   endtask
   task automatic t_track();
      logic [W-1:0] r;
      lvl = {16'h0500, 16'h0400, 16'h0401, 16'h03ff};
      smp(1);
      `CHK(cnt(0), 16'h03ff)
      for (int g = 1; g < N; g++) `CHK(cnt(g), 16'h0400)
      lvl = {N{16'h0320}};
      smp(40);
      pulse(reseed_set_in);
      // look before the next sample lets the reference drift again
      @(negedge core_clk_in);
      `CHK(reseed_pending_out, 1'b0)
      for (int g = 0; g < N; g++) `CHK(rf(g), 16'h0320)
      lvl[15:0] = 16'h02c0;
      smp(2);
      `CHK(touch_out, 4'h1)
      r = rf(0);
      smp(28);
      `CHK(touch_out, 4'h1)
      `CHK(rf(0), r)
      lvl[15:0] = 16'h0330;
      smp(4);
      `CHK(rf(0) <= 16'h0324, 1'b1)
      smp(40);
      `CHK(touch_out, 4'h0)
      // the truncating blend settles one lsb under a rising level
      `CHK(rf(0), 16'h032f)
   endtask
   task automatic t_power();
      logic seen;
      seen = 1'b0;
      smp(20);
      `CHK(power_mode_out, cap_tracker_pkg::normal_power_mode)
      mode_timeout_in = 8'h04;
      repeat (12) begin
         smp(1);
         if (power_mode_out === cap_tracker_pkg::low_power_mode) seen = 1'b1;
      end
      `CHK(seen, 1'b1)
      `CHK(power_mode_out, cap_tracker_pkg::ultra_low_power_mode)
      wake_chan_in = 2'h2;
      lvl[47:16] = {16'h032a, 16'h032a};
      smp(1);
      `CHK(cnt(2), 16'h032a)
      smp(8);
      `CHK(cnt(1), 16'h032a)
      lvl[47:32] = 16'h02c0;
      smp(30);
      `CHK(power_mode_out, cap_tracker_pkg::normal_power_mode)
      mode_timeout_in = 8'h00;
      lvl = {N{16'h0320}};
      smp(40);
   endtask
   task automatic t_tune();
      logic [9:0] cv [4] = '{10'h200, 10'h000, 10'h3ff, 10'h3fe};
      logic [3:0] ev = 4'b0110;
      for (int i = 0; i < 4; i++) begin
         comp_in[19:10] = cv[i];
         tune();
         `CHK(tuning_error_flag_out, ev[i])
      end
      // 900 sits exactly on the default window edge, past the narrow one
      lvl[63:48] = 16'h0384;
      smp(1);
      `CHK(cnt(3), 16'h0384)
      tune();
      `CHK(tuning_error_flag_out, 1'b0)
      bound_default_in = 1'b0;
      tune();
      `CHK(tuning_error_flag_out, 1'b1)
      bound_default_in = 1'b1;
      smp(3);
      `CHK(tuning_error_flag_out, 1'b1)
   endtask
   task automatic t_retune();
      int k;
      lvl = {N{16'h03e8}};
      smp(1);
      pulse(reseed_set_in);
      smp(2);
      retune_en_in = 1'b1;
      k = retunes;
      for (int c = 0; c < 400 && retunes == k; c++) @(negedge core_clk_in);
      `CHK(retunes, k + 1)
      for (int c = 0; c < 400 && tuning_out !== 1'b0; c++) @(negedge core_clk_in);
      repeat (2) @(negedge core_clk_in);
      `CHK(retunes, k + 1)
      `CHK(tuning_error_flag_out, 1'b1)
      smp(5);
      `CHK(retunes, k + 1)
      smp(12);
      `CHK(retunes > k + 1, 1'b1)
      retune_en_in = 1'b0;
      for (int c = 0; c < 400 && tuning_out !== 1'b0; c++) @(negedge core_clk_in);
   endtask
   task automatic t_restart();
      pulse(soft_restart_in);
      `CHK(reset_flag_out, 1'b1)
      `CHK(cnt(0), 16'h0000)
      `CHK(power_mode_out, cap_tracker_pkg::normal_power_mode)
      tune();
      pulse(ack_reset_in);
   endtask
   initial begin
      repeat (4) @(negedge core_clk_in);
      rst_in = 1'b0;
      t_xfer();
      t_reset();
      t_track();
      t_power();
      t_tune();
      t_retune();
      t_restart();
      test_done();
   end
   // whole run is a few thousand cycles; this margin only catches a hang
   initial begin
      #(20 * 40000);
      error_cnt++;
      test_done();
   end
endmodule
